// ==== shared/usb_pkg.sv ====
// Shared constants and carrier types for the serial bridge
package usb_pkg;
    localparam int CLK_HZ = 125000000;
    localparam int FRAME_BYTES = 64;
    localparam int TX_FRAMES = 4;
    localparam int RX_FRAMES = 8;
    localparam int BAUD_MIN = 1200;
    localparam int BAUD_MAX = 500000;
    localparam int BAUD_OVR = 9600;
    localparam int BAUD_MID = 115200;
    localparam int BAUD_HI = 460800;
    localparam int LEGACY_MAX_CHARS = 50;
    localparam int NEW_MIN_CHARS = 498;
    localparam int BREAK_BITS = 11;
    localparam int FLUSH_MS = 100;
    localparam int SOF_PER_MS = 1;
    localparam int FLUSH_SOFS = FLUSH_MS * SOF_PER_MS;
    // Longest break: 11 bits at the lowest rate, rounded down
    localparam int BREAK_MAX_CYC = (CLK_HZ / BAUD_MIN) * BREAK_BITS;
    localparam logic [7:0] CHAR_NUL = 8'h00;

    typedef enum logic [1:0] {USB_OVR_TERM, USB_OVR_9600, USB_OVR_115200, USB_OVR_460800}
        usb_ovr_rate_type;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
    } usb_byte_type;

    typedef struct packed {
        logic erase;
        logic fuse_write;
        logic lock_write;
        logic [7:0] data;
        logic [7:0] mask;
    } usb_prog_type;
endpackage

// ==== src/usb_frame_mem.sv ====
// Frame store: simple dual-port memory with registered read data
module usb_frame_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 256
) (
    input wire logic clk,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem_reg [DEPTH];

    initial begin
        if (DEPTH < 2)
            $error("usb_frame_mem: DEPTH too small");
    end

    always_ff @(posedge clk)
    begin
        if (ce && wr_en)
            mem_reg[wr_addr] <= wr_data;
        if (ce)
            rd_data <= mem_reg[rd_addr];
    end
endmodule // usb_frame_mem

// ==== src/usb_serial_uart_bridge.sv ====
// Serial bridge between a USB virtual serial port and a target UART
module usb_serial_uart_bridge #(
    parameter int BREAK_MAX = usb_pkg::BREAK_MAX_CYC,
    parameter bit LEGACY = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic dtr,
    input wire logic [31:0] baud_req,
    input wire logic line_configured,
    input wire usb_pkg::usb_byte_type host_in,
    output logic host_ready,
    input wire logic ovr_start,
    input wire usb_pkg::usb_ovr_rate_type ovr_rate,
    input wire usb_pkg::usb_byte_type ovr_in,
    output logic ovr_ready,
    output logic ovr_busy,
    input wire logic erase_cmd,
    input wire usb_pkg::usb_prog_type prog_in,
    input wire logic [7:0] fuse_keep_mask,
    output usb_pkg::usb_prog_type prog_out,
    input wire logic break_req,
    input wire logic break_hold,
    input wire logic [15:0] break_ms,
    input wire logic sof,
    output usb_pkg::usb_byte_type rx_out,
    input wire logic rx_out_ready,
    output logic rx_overrun,
    output logic txd,
    output logic txd_oe,
    input wire logic rxd_pin
);
    localparam int TXD = usb_pkg::FRAME_BYTES * usb_pkg::TX_FRAMES;
    localparam int RXD = usb_pkg::FRAME_BYTES * usb_pkg::RX_FRAMES;
    localparam int BW = $clog2(usb_pkg::FRAME_BYTES);

    initial begin
        if (BREAK_MAX < 1)
            $error("usb_serial_uart_bridge: BREAK_MAX must be positive");
    end

    typedef enum logic [1:0] {usb_idle_type_s, usb_data_s, usb_break_s, usb_mark_s} usb_tx_state_type;

    // Input synchroniser for the receive pin
    logic rxd_s1_reg, rxd_s2_reg;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rxd_s1_reg <= 1'b1;
            rxd_s2_reg <= 1'b1;
        end
        else if (ce)
        begin
            rxd_s1_reg <= rxd_pin;
            rxd_s2_reg <= rxd_s1_reg;
        end
    end

    // Rate selection
    // rate clamp
    wire [31:0] baud_clamped = (baud_req < 32'(usb_pkg::BAUD_MIN)) ? 32'(usb_pkg::BAUD_MIN) :
        (baud_req > 32'(usb_pkg::BAUD_MAX)) ? 32'(usb_pkg::BAUD_MAX) : baud_req;
    logic ovr_reg;
    usb_pkg::usb_ovr_rate_type ovr_rate_reg;
    wire [31:0] ovr_baud = (ovr_rate_reg == usb_pkg::USB_OVR_115200) ? 32'(usb_pkg::BAUD_MID) :
        (ovr_rate_reg == usb_pkg::USB_OVR_460800) ? 32'(usb_pkg::BAUD_HI) :
        (LEGACY && line_configured && ovr_rate_reg == usb_pkg::USB_OVR_TERM) ? baud_clamped :
        32'(usb_pkg::BAUD_OVR);
    wire [31:0] baud = ovr_reg ? ovr_baud : baud_clamped;
    wire [31:0] bit_cyc = 32'(usb_pkg::CLK_HZ) / baud;

    wire session = dtr && !ovr_reg;

    // Host-to-target frame ring
    logic [$clog2(TXD)-1:0] tx_wa_reg, tx_ra_reg;
    logic [2:0] tx_full_frames_reg, tx_free_reg;
    logic [7:0] tx_rd_data;
    wire tx_frame_done_w, tx_frame_read_w;
    assign host_ready = session && (tx_free_reg != 3'd0);
    wire host_wr = host_in.valid && host_ready;
    // whole frame queued on last byte or at 64
    assign tx_frame_done_w = host_wr && (host_in.last || tx_wa_reg[BW-1:0] == BW'(63));
    logic [7:0] tx_len_reg [usb_pkg::TX_FRAMES];
    usb_frame_mem #(.WIDTH(8), .DEPTH(TXD)) u_tx_mem (
        .clk(clk), .ce(ce), .wr_en(host_wr), .wr_addr(tx_wa_reg), .wr_data(host_in.data),
        .rd_addr(tx_ra_reg), .rd_data(tx_rd_data)
    );

    // Override byte path: single register stage
    logic [15:0] ovr_cnt_reg;
    logic ovr_stop_reg;
    logic ovr_end_reg;
    usb_pkg::usb_byte_type ovr_hold_reg;
    wire ovr_limit = LEGACY ? (ovr_cnt_reg >= 16'(usb_pkg::LEGACY_MAX_CHARS)) : 1'b0;
    assign ovr_ready = ovr_reg && !ovr_hold_reg.valid;
    assign ovr_busy = ovr_reg;

    // Transmitter
    usb_tx_state_type tx_state_reg;
    logic [31:0] tx_cnt_reg, brk_cnt_reg;
    logic [3:0] tx_bit_reg;
    logic [9:0] tx_sh_reg;
    logic tx_fetch_reg, tx_frame_active_reg;
    logic [6:0] tx_left_reg;
    logic brk_pend_reg;
    wire bit_tick = (tx_cnt_reg == 32'd0);
    wire [31:0] brk_req_cyc = 32'(break_ms) * 32'(usb_pkg::CLK_HZ / 1000);
    wire [31:0] brk_len = (brk_req_cyc > 32'(BREAK_MAX)) ? 32'(BREAK_MAX) : brk_req_cyc;
    wire [31:0] brk_min = bit_cyc * 32'(usb_pkg::BREAK_BITS);
    wire [31:0] brk_load = (brk_len < brk_min) ? brk_min : brk_len;
    assign tx_frame_read_w = tx_frame_active_reg && tx_state_reg == usb_data_s && bit_tick &&
        tx_bit_reg == 4'd9 && tx_left_reg == 7'd0;
    wire tx_have = tx_full_frames_reg != 3'd0;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ovr_reg <= 1'b0;
            ovr_rate_reg <= usb_pkg::USB_OVR_TERM;
            ovr_cnt_reg <= 16'h0000;
            ovr_stop_reg <= 1'b0;
            ovr_end_reg <= 1'b0;
            ovr_hold_reg <= '0;
        end
        else if (ce)
        begin
            if (ovr_start && !ovr_reg)
            begin
                ovr_reg <= 1'b1;
                ovr_rate_reg <= ovr_rate;
                ovr_cnt_reg <= 16'h0000;
                ovr_stop_reg <= 1'b0;
                ovr_end_reg <= 1'b0;
            end
            else if (ovr_reg && ovr_ready && ovr_in.valid)
            begin
                if (!ovr_stop_reg && !ovr_limit && !(!LEGACY && ovr_in.data == usb_pkg::CHAR_NUL))
                begin
                    ovr_hold_reg <= ovr_in;
                    ovr_cnt_reg <= ovr_cnt_reg + 16'h0001;
                end
                if (!LEGACY && ovr_in.data == usb_pkg::CHAR_NUL)
                    ovr_stop_reg <= 1'b1;
                if (ovr_in.last)
                    ovr_end_reg <= 1'b1;
            end
            else if (ovr_hold_reg.valid && tx_state_reg == usb_idle_type_s)
                ovr_hold_reg.valid <= 1'b0;
            // file accepted until its final byte
            // Rate must not switch back while the last character is still on the line
            else if (ovr_reg && ovr_end_reg && !ovr_hold_reg.valid && tx_state_reg == usb_idle_type_s)
                ovr_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tx_state_reg <= usb_idle_type_s;
            tx_cnt_reg <= 32'd0;
            brk_cnt_reg <= 32'd0;
            tx_bit_reg <= 4'd0;
            tx_sh_reg <= 10'h3FF;
            txd <= 1'b1;
            txd_oe <= 1'b0;
            tx_fetch_reg <= 1'b0;
            tx_frame_active_reg <= 1'b0;
            tx_left_reg <= 7'd0;
            tx_ra_reg <= '0;
            brk_pend_reg <= 1'b0;
        end
        else if (ce)
        begin
            if (dtr || ovr_reg)
                txd_oe <= 1'b1;
            tx_cnt_reg <= bit_tick ? 32'd0 : tx_cnt_reg - 32'd1;
            tx_fetch_reg <= 1'b0;
            unique case (tx_state_reg)
                usb_idle_type_s:
                begin
                    txd <= 1'b1;
                    if (break_req && !ovr_reg)
                    begin
                        tx_state_reg <= usb_break_s;
                        brk_cnt_reg <= brk_load;
                    end
                    else if (ovr_hold_reg.valid)
                    begin
                        tx_sh_reg <= {1'b1, ovr_hold_reg.data, 1'b0};
                        tx_bit_reg <= 4'd0;
                        tx_cnt_reg <= bit_cyc - 32'd1;
                        tx_state_reg <= usb_data_s;
                    end
                    else if (tx_frame_active_reg && !tx_fetch_reg && session)
                    begin
                        tx_sh_reg <= {1'b1, tx_rd_data, 1'b0};
                        tx_bit_reg <= 4'd0;
                        tx_cnt_reg <= bit_cyc - 32'd1;
                        tx_state_reg <= usb_data_s;
                    end
                    else if (!tx_frame_active_reg && tx_have && session)
                    begin
                        tx_frame_active_reg <= 1'b1;
                        tx_left_reg <= 7'(tx_len_reg[tx_ra_reg[$clog2(TXD)-1:BW]]);
                        tx_fetch_reg <= 1'b1;
                    end
                end
                usb_data_s:
                begin
                    txd <= tx_sh_reg[tx_bit_reg];
                    if (break_req && !ovr_reg)
                    begin
                        tx_state_reg <= usb_break_s;
                        brk_cnt_reg <= brk_load;
                        brk_pend_reg <= tx_frame_active_reg;
                        tx_frame_active_reg <= 1'b0;
                    end
                    else if (bit_tick)
                    begin
                        tx_cnt_reg <= bit_cyc - 32'd1;
                        if (tx_bit_reg == 4'd9)
                        begin
                            tx_state_reg <= usb_idle_type_s;
                            if (tx_frame_active_reg)
                            begin
                                tx_ra_reg <= tx_ra_reg + 1'b1;
                                tx_fetch_reg <= 1'b1;
                                tx_left_reg <= tx_left_reg - 7'd1;
                                if (tx_left_reg == 7'd0)
                                begin
                                    tx_frame_active_reg <= 1'b0;
                                    tx_ra_reg <= {tx_ra_reg[$clog2(TXD)-1:BW] + 1'b1, BW'(0)};
                                end
                            end
                        end
                        else
                            tx_bit_reg <= tx_bit_reg + 4'd1;
                    end
                end
                usb_break_s:
                begin
                    txd <= 1'b0;
                    brk_cnt_reg <= (brk_cnt_reg == 32'd0) ? 32'd0 : brk_cnt_reg - 32'd1;
                    if (brk_cnt_reg == 32'd0 && !break_hold)
                    begin
                        tx_state_reg <= usb_mark_s;
                        tx_cnt_reg <= bit_cyc - 32'd1;
                        brk_pend_reg <= 1'b0;
                        if (brk_pend_reg)
                            tx_ra_reg <= {tx_ra_reg[$clog2(TXD)-1:BW] + 1'b1, BW'(0)};
                    end
                end
                usb_mark_s:
                begin
                    // one idle bit before next data
                    txd <= 1'b1;
                    if (bit_tick)
                        tx_state_reg <= usb_idle_type_s;
                end
            endcase
        end
    end

    wire brk_drop = tx_state_reg == usb_break_s && brk_cnt_reg == 32'd0 && !break_hold && brk_pend_reg;
    wire tx_release = tx_frame_read_w || brk_drop;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tx_wa_reg <= '0;
            tx_full_frames_reg <= 3'd0;
            tx_free_reg <= 3'(usb_pkg::TX_FRAMES);
            for (int i = 0; i < usb_pkg::TX_FRAMES; i++)
                tx_len_reg[i] <= 8'h00;
        end
        else if (ce)
        begin
            if (host_wr)
                tx_wa_reg <= tx_frame_done_w ?
                    {tx_wa_reg[$clog2(TXD)-1:BW] + 1'b1, BW'(0)} : tx_wa_reg + 1'b1;
            if (tx_frame_done_w)
                tx_len_reg[tx_wa_reg[$clog2(TXD)-1:BW]] <= 8'(tx_wa_reg[BW-1:0]);
            tx_full_frames_reg <= tx_full_frames_reg + 3'(tx_frame_done_w)
                - 3'(tx_release && !tx_frame_read_w ? 1'b1 : tx_frame_read_w);
            tx_free_reg <= tx_free_reg - 3'(tx_frame_done_w) + 3'(tx_release);
        end
    end

    // Receiver
    logic [31:0] rx_cnt_reg;
    logic [3:0] rx_bit_reg;
    logic [7:0] rx_sh_reg;
    logic rx_busy_reg, rx_strobe_reg;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rx_cnt_reg <= 32'd0;
            rx_bit_reg <= 4'd0;
            rx_sh_reg <= 8'h00;
            rx_busy_reg <= 1'b0;
            rx_strobe_reg <= 1'b0;
        end
        else if (ce)
        begin
            rx_strobe_reg <= 1'b0;
            if (!rx_busy_reg)
            begin
                if (!rxd_s2_reg && session)
                begin
                    rx_busy_reg <= 1'b1;
                    rx_cnt_reg <= bit_cyc >> 1;
                    rx_bit_reg <= 4'd0;
                end
            end
            else if (rx_cnt_reg != 32'd0)
                rx_cnt_reg <= rx_cnt_reg - 32'd1;
            else
            begin
                rx_cnt_reg <= bit_cyc - 32'd1;
                rx_bit_reg <= rx_bit_reg + 4'd1;
                if (rx_bit_reg >= 4'd1 && rx_bit_reg <= 4'd8)
                    rx_sh_reg <= {rxd_s2_reg, rx_sh_reg[7:1]};
                if (rx_bit_reg == 4'd9)
                begin
                    rx_busy_reg <= 1'b0;
                    rx_strobe_reg <= rxd_s2_reg && session;
                end
                if (rx_bit_reg == 4'd0 && rxd_s2_reg)
                    rx_busy_reg <= 1'b0;
            end
        end
    end

    // Target-to-host frame ring
    logic [2:0] rx_wf_reg, rx_rf_reg;
    logic [3:0] rx_used_reg;
    logic [BW:0] rx_wb_reg;
    logic [BW-1:0] rx_rb_reg;
    logic [6:0] rx_len_reg [usb_pkg::RX_FRAMES];
    logic [7:0] sof_cnt_reg;
    logic [7:0] rx_rd_data;
    logic rx_rd_ok_reg;
    wire flush_due = sof && sof_cnt_reg >= 8'(usb_pkg::FLUSH_SOFS - 1);
    wire rx_close = (rx_strobe_reg && rx_wb_reg == 7'(usb_pkg::FRAME_BYTES - 1)) ||
        (flush_due && rx_wb_reg != '0 && !rx_strobe_reg);
    wire rx_pop = rx_out.valid && rx_out_ready && rx_out.last;
    wire rx_full = rx_used_reg == 4'(usb_pkg::RX_FRAMES - 1);
    wire rx_wr = rx_strobe_reg;
    usb_frame_mem #(.WIDTH(8), .DEPTH(RXD)) u_rx_mem (
        .clk(clk), .ce(ce), .wr_en(rx_wr), .wr_addr({rx_wf_reg, rx_wb_reg[BW-1:0]}),
        .wr_data(rx_sh_reg), .rd_addr({rx_rf_reg, rx_rb_reg}), .rd_data(rx_rd_data)
    );

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rx_wf_reg <= 3'd0;
            rx_rf_reg <= 3'd0;
            rx_used_reg <= 4'd0;
            rx_wb_reg <= '0;
            rx_rb_reg <= '0;
            sof_cnt_reg <= 8'h00;
            rx_overrun <= 1'b0;
            rx_out <= '0;
            rx_rd_ok_reg <= 1'b0;
            for (int i = 0; i < usb_pkg::RX_FRAMES; i++)
                rx_len_reg[i] <= 7'd0;
        end
        else if (ce)
        begin
            rx_overrun <= 1'b0;
            if (sof)
                sof_cnt_reg <= flush_due ? 8'h00 : sof_cnt_reg + 8'h01;
            if (rx_wr && !rx_close)
                rx_wb_reg <= rx_wb_reg + 1'b1;
            if (rx_close)
            begin
                rx_wb_reg <= '0;
                if (rx_full && !rx_pop)
                    rx_overrun <= 1'b1;
                else
                begin
                    rx_len_reg[rx_wf_reg] <= 7'(rx_wb_reg) + 7'(rx_wr);
                    rx_wf_reg <= rx_wf_reg + 3'd1;
                end
            end
            rx_used_reg <= rx_used_reg + 4'(rx_close && !(rx_full && !rx_pop)) - 4'(rx_pop);
            // Read pipeline: memory answers a cycle after the address
            rx_rd_ok_reg <= (rx_used_reg != 4'd0) && !rx_out.valid && !rx_rd_ok_reg;
            if (rx_rd_ok_reg)
            begin
                rx_out.valid <= 1'b1;
                rx_out.data <= rx_rd_data;
                rx_out.last <= 7'(rx_rb_reg) + 7'd1 >= rx_len_reg[rx_rf_reg];
            end
            else if (rx_out.valid && rx_out_ready)
            begin
                rx_out.valid <= 1'b0;
                rx_rb_reg <= rx_out.last ? '0 : rx_rb_reg + 1'b1;
                if (rx_out.last)
                    rx_rf_reg <= rx_rf_reg + 3'd1;
            end
        end
    end

    // Programming path
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            prog_out <= '0;
        else if (ce)
        begin
            prog_out.erase <= erase_cmd;
            prog_out.lock_write <= 1'b0;
            prog_out.fuse_write <= prog_in.fuse_write;
            prog_out.data <= prog_in.fuse_write ? (prog_in.data & fuse_keep_mask) : prog_in.data;
            prog_out.mask <= prog_in.mask;
        end
    end
endmodule // usb_serial_uart_bridge

// ==== sim/usb_bridge_checker.sv ====
// Concurrent checks on the serial bridge ports
module usb_bridge_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic dtr,
    input wire logic erase_cmd,
    input wire usb_pkg::usb_prog_type prog_in,
    input wire logic [7:0] fuse_keep_mask,
    input wire usb_pkg::usb_prog_type prog_out,
    input wire logic host_ready,
    input wire logic ovr_busy,
    input wire logic break_req,
    input wire logic txd,
    input wire usb_pkg::usb_byte_type rx_out,
    input wire logic rx_out_ready,
    input wire logic rx_overrun
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    erase_pass_a: assert property (ce && erase_cmd |=> prog_out.erase)
        else $error("erase command not forwarded");
    lock_drop_a: assert property (!prog_out.lock_write)
        else $error("lock write reached target");
    fuse_mask_a: assert property (ce && prog_in.fuse_write |=>
        prog_out.data == ($past(prog_in.data) & $past(fuse_keep_mask)))
        else $error("fuse data not masked");
    dtr_gate_a: assert property (!dtr |-> !host_ready)
        else $error("host data accepted without session");
    ovr_hold_a: assert property (ovr_busy |-> !host_ready)
        else $error("terminal data accepted during override");
    break_low_a: assert property (ce && break_req && !ovr_busy |-> ##[1:3] !txd)
        else $error("break did not pull line low");
    rx_hold_a: assert property (rx_out.valid && !rx_out_ready |=>
        rx_out.valid && $stable(rx_out.data))
        else $error("receive frame byte dropped before taken");
    overrun_pulse_a: assert property (rx_overrun |=> !rx_overrun)
        else $error("overrun flag not a pulse");
endmodule // usb_bridge_checker

// ==== sim/usb_target_model.sv ====
// Target UART model: 8N1 receiver on the bridge output, transmitter toward it
module usb_target_model #(
    parameter int BIT = 250
) (
    input wire logic clk,
    input wire logic txd,
    input wire logic txd_oe,
    output logic rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic line;
    logic [7:0] sh;
    logic [7:0] got = 8'h00;
    int got_cnt = 0;
    // Target enables its own pull-up, so an undriven line reads high
    assign line = txd_oe ? txd : 1'b1;
    initial rxd = 1'b1;
    always
    begin
        @(negedge line);
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT) @(posedge clk);
            sh[i] = line;
        end
        repeat (BIT) @(posedge clk);
        got = sh;
        got_cnt++;
    end
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            rxd <= f[i];
            repeat (BIT) @(posedge clk);
        end
    endtask
endmodule // usb_target_model

// ==== sim/usb_serial_uart_bridge_tb.sv ====
// Self-checking bench for the serial bridge
module usb_serial_uart_bridge_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, ce = 1, dtr = 0, line_configured = 0, ovr_start = 0;
    logic erase_cmd = 0, break_req = 0, break_hold = 0, sof = 0, rx_out_ready = 1;
    logic [31:0] baud_req = 32'hFFFFFFFF;
    logic [15:0] break_ms = 16'h0000;
    logic [7:0] fuse_keep_mask = 8'hFF;
    usb_pkg::usb_ovr_rate_type ovr_rate = usb_pkg::USB_OVR_TERM;
    usb_pkg::usb_byte_type host_in = '0, ovr_in = '0, rx_out;
    usb_pkg::usb_prog_type prog_in = '0, prog_out;
    logic host_ready, ovr_ready, ovr_busy, rx_overrun, txd, txd_oe, rxd_pin;
    int miscompares = 0, cmp_count = 0, n, c;
    usb_serial_uart_bridge #(.BREAK_MAX(4000), .LEGACY(1'b0)) DUT (.clk, .rst, .ce, .dtr,
        .baud_req, .line_configured, .host_in, .host_ready, .ovr_start, .ovr_rate, .ovr_in,
        .ovr_ready, .ovr_busy, .erase_cmd, .prog_in, .fuse_keep_mask, .prog_out, .break_req,
        .break_hold, .break_ms, .sof, .rx_out, .rx_out_ready, .rx_overrun, .txd, .txd_oe,
        .rxd_pin);
    // Rate request is clamped to the top limit, 250 cycles a bit
    usb_target_model #(.BIT(250)) tgt (.clk, .txd, .txd_oe, .rxd(rxd_pin));
    initial forever #4 clk = ~clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic t_host_byte();
        n = tgt.got_cnt;
        check(host_ready, 1'b0);
        dtr <= 1'b1;
        host_in <= '{1'b1, 8'hA5, 1'b1};
        c = 0;
        do @(negedge clk); while (!host_ready && ++c < 100);
        @(posedge clk);
        host_in <= '0;
        c = 0;
        while (tgt.got_cnt == n && c++ < 5000) @(posedge clk);
        check(tgt.got, 8'hA5);
    endtask
    task automatic t_prog();
        @(posedge clk);
        erase_cmd <= 1'b1;
        fuse_keep_mask <= 8'h7F;
        prog_in <= '{1'b0, 1'b1, 1'b1, 8'hFF, 8'hFF};
        @(posedge clk);
        erase_cmd <= 1'b0;
        prog_in <= '0;
        @(negedge clk);
        check(prog_out.erase, 1'b1);
        check(prog_out.lock_write, 1'b0);
        check(prog_out.data, 8'h7F);
    endtask
    task automatic t_rx_flush();
        @(posedge clk);
        rx_out_ready <= 1'b0;
        tgt.send(8'h3C);
        // host stalls briefly, then drains the offered frame
        repeat (100)
        begin
            @(posedge clk);
            sof <= 1'b1;
            @(posedge clk);
            sof <= 1'b0;
        end
        c = 0;
        do @(negedge clk); while (!rx_out.valid && ++c < 2000);
        repeat (3) @(negedge clk);
        check(rx_out.valid, 1'b1);
        check(rx_out.data, 8'h3C);
        check(rx_out.last, 1'b1);
        @(posedge clk);
        rx_out_ready <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        check(rx_out.valid, 1'b0);
    endtask
    task automatic t_override();
        @(posedge clk);
        ovr_rate <= usb_pkg::USB_OVR_460800;
        ovr_start <= 1'b1;
        @(posedge clk);
        ovr_start <= 1'b0;
        ovr_in <= '{1'b1, 8'h01, 1'b0};
        c = 0;
        do @(negedge clk); while (!ovr_ready && ++c < 100);
        check(ovr_busy, 1'b1);
        check(host_ready, 1'b0);
        @(posedge clk);
        ovr_in <= '{1'b1, 8'h00, 1'b1};
        c = 0;
        do @(negedge clk); while (!ovr_ready && ++c < 100);
        @(posedge clk);
        ovr_in <= '0;
        c = 0;
        do @(negedge clk); while (txd && ++c < 100);
        n = 0;
        while (!txd && n < 1000)
        begin
            @(negedge clk);
            n++;
        end
        check(n, usb_pkg::CLK_HZ / usb_pkg::BAUD_HI);
        check(ovr_busy, 1'b1);
        c = 0;
        while (ovr_busy && c++ < 4000) @(negedge clk);
        check(ovr_busy, 1'b0);
        n = 0;
        repeat (300)
        begin
            @(negedge clk);
            if (!txd)
                n++;
        end
        check(n, 0);
    endtask
    task automatic t_break();
        @(posedge clk);
        break_req <= 1'b1;
        @(posedge clk);
        break_req <= 1'b0;
        c = 0;
        do @(negedge clk); while (txd && ++c < 10);
        n = 0;
        while (!txd && n < 6000)
        begin
            @(negedge clk);
            n++;
        end
        check(n >= 2750, 1'b1);
        check(n <= 4010, 1'b1);
        check(txd, 1'b1);
        repeat (300) @(posedge clk);
        break_req <= 1'b1;
        break_hold <= 1'b1;
        @(posedge clk);
        break_req <= 1'b0;
        repeat (3000) @(posedge clk);
        break_hold <= 1'b0;
        @(negedge clk);
        check(txd, 1'b0);
        repeat (260) @(negedge clk);
        check(txd, 1'b1);
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        check({txd, txd_oe, rx_out.valid, ovr_busy}, 4'h8);
        check(prog_out, '0);
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_host_byte();
        t_prog();
        t_rx_flush();
        t_override();
        t_break();
        summarize();
    end
    initial
    begin
        repeat (60000) @(posedge clk);
        miscompares++;
        summarize();
    end
endmodule // usb_serial_uart_bridge_tb
bind usb_serial_uart_bridge usb_bridge_checker chk (.clk, .rst, .ce, .dtr, .erase_cmd,
    .prog_in, .fuse_keep_mask, .prog_out, .host_ready, .ovr_busy, .break_req, .txd,
    .rx_out, .rx_out_ready, .rx_overrun);
